// File: common/mpg_pkg.sv
// mpg_pkg: constants, register map and types of the memory partition guard
// assumes: 32-bit register words, byte addresses on an 8-bit register port
package mpg_pkg;
  // ==========================================================
  // sizes
  localparam int NPART = 4;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NTRACE = 4;
  localparam int NEV = 4;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [AW-1:0] OFS_OPMODE = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_MASK = 8'h08;
  localparam logic [AW-1:0] OFS_LIFE = 8'h0C;
  localparam logic [AW-1:0] OFS_VADDR = 8'h10;
  localparam logic [1:0] BANK_MISC = 2'h0;
  localparam logic [1:0] BANK_FLASH = 2'h1;
  localparam logic [1:0] BANK_RAM = 2'h2;
  localparam logic [3:0] TRACE_HI = 4'h2;
  localparam logic [1:0] FLD_BASE = 2'h0;
  localparam logic [1:0] FLD_LIMIT = 2'h1;
  localparam logic [1:0] FLD_ATTR = 2'h2;

  // ==========================================================
  // field positions
  localparam int OPM_FLASH_BOOT = 0;
  localparam int OPM_ROM_USER_RD = 1;
  localparam int OPM_FLASH_USER_WR = 2;
  localparam int OPM_LOCK = 3;
  localparam int OPM_W = 4;
  localparam int ATTR_EN = 0;
  localparam int ATTR_RD = 1;
  localparam int ATTR_WR = 2;
  localparam int ATTR_EX = 3;
  localparam int ATTR_W = 4;
  localparam int EV_ACCESS = 0;
  localparam int EV_PRIV = 1;
  localparam int EV_TRACE = 2;
  localparam int EV_TEST = 3;
  localparam int LIFE_TEST = 0;
  localparam int LIFE_NORMAL = 1;

  // ==========================================================
  // values after reset
  localparam logic [OPM_W-1:0] OPM_RST = 4'h0;
  localparam logic [DW-1:0] BASE_RST = 32'hFFFF_FFFF;
  localparam logic [DW-1:0] LIMIT_RST = 32'h0000_0000;
  localparam logic [ATTR_W-1:0] ATTR_RST = 4'h0;
  localparam logic [NEV-1:0] EV_RST = 4'h0;
  localparam logic [DW-1:0] WORD_RST = 32'h0000_0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {SP_ROM, SP_FLASH, SP_RAM, SP_SFR} mpg_space_t;
  typedef enum {LC_BOOT, LC_FACTORY, LC_TEST, LC_NORMAL} mpg_life_t;
endpackage : mpg_pkg

// File: common/mpg_chk_if.sv
// mpg_chk_if: partition configuration and one access request to be judged
// assumes: driven by mpg_top, judged combinationally by mpg_part_check
`timescale 1ns/10ps
interface mpg_chk_if;
  import mpg_pkg::*;
  logic [DW-1:0] fl_base [NPART];
  logic [DW-1:0] fl_limit [NPART];
  logic [ATTR_W-1:0] fl_attr [NPART];
  logic [DW-1:0] ram_base [NPART];
  logic [DW-1:0] ram_limit [NPART];
  logic [ATTR_W-1:0] ram_attr [NPART];
  logic [OPM_W-1:0] opmode;
  logic [DW-1:0] addr;
  mpg_space_t space;
  logic write;
  logic exec;
  logic priv;
  logic permit;
  modport cfg (output fl_base, fl_limit, fl_attr, ram_base, ram_limit, ram_attr,
    opmode, addr, space, write, exec, priv, input permit);
  modport chk (input fl_base, fl_limit, fl_attr, ram_base, ram_limit, ram_attr,
    opmode, addr, space, write, exec, priv, output permit);
endinterface : mpg_chk_if

// File: hdl/mpg_part_check.sv
// mpg_part_check: judges one access against partitions and mode attributes
// assumes: purely combinational, result registered by the caller
`timescale 1ns/10ps
module mpg_part_check
  import mpg_pkg::*;
(
  mpg_chk_if.chk chk
);
  // ==========================================================
  // helpers
  function automatic logic in_part(input logic [DW-1:0] a, input logic [DW-1:0] b,
    input logic [DW-1:0] l, input logic [ATTR_W-1:0] attr);
    return attr[ATTR_EN] && (a >= b) && (a <= l);
  endfunction : in_part

  function automatic logic rights_ok(input logic [ATTR_W-1:0] attr, input logic wr,
    input logic ex);
    return wr ? attr[ATTR_WR] : (ex ? attr[ATTR_EX] : attr[ATTR_RD]);
  endfunction : rights_ok

  // ==========================================================
  // partition match
  logic fl_ok;
  logic ram_ok;
  always_comb begin
    fl_ok = 1'b0;
    ram_ok = 1'b0;
    for (int i = 0; i < NPART; i++) begin
      if (in_part(chk.addr, chk.fl_base[i], chk.fl_limit[i], chk.fl_attr[i]) &&
          rights_ok(chk.fl_attr[i], chk.write, chk.exec)) begin
        fl_ok = 1'b1;
      end
      if (in_part(chk.addr, chk.ram_base[i], chk.ram_limit[i], chk.ram_attr[i]) &&
          rights_ok(chk.ram_attr[i], chk.write, chk.exec)) begin
        ram_ok = 1'b1;
      end
    end
  end

  // ==========================================================
  // decision by space and privilege
  always_comb begin
    case (chk.space)
      SP_ROM: begin
        chk.permit = !chk.opmode[OPM_FLASH_BOOT] && !chk.write &&
          (chk.priv || chk.opmode[OPM_ROM_USER_RD]);
      end
      SP_FLASH: begin
        chk.permit = chk.priv ||
          (fl_ok && (!chk.write || chk.opmode[OPM_FLASH_USER_WR]));
      end
      SP_RAM: begin
        chk.permit = chk.priv || ram_ok;
      end
      default: begin
        chk.permit = chk.priv;
      end
    endcase
  end
endmodule : mpg_part_check

// File: hdl/mpg_top.sv
// mpg_top: memory partition guard with operating-mode selector and life cycle
// assumes: one clock, all inputs from logic on clk_i, core holds requests one cycle
//
// What this block does
// - all registers take defaults at power-on reset
// - ROM and flash attributes default without software
// - memory split into partitions, each own attributes
// - user accesses limited to configured partitions
// - mode selector sets ROM, flash attributes, mode
// - configuration writes only take effect when privileged
// - each partition has base and limit registers
// - separate partition register sets for flash, RAM
// - separate attribute register per partition
// - normal mode permanent, never back to test
// - traceability data read-only after normal mode
// - test mode entry needs valid password
// - test commands disabled in normal mode
// - functional test only in test mode
// - prohibited area accesses are trapped
// - decisions depend on privileged or user mode
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module mpg_top
  import mpg_pkg::*;
#(
  parameter logic [DW-1:0] TEST_PWD = 32'h3C5A_A5C3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic priv_i,
  output logic [DW-1:0] rdata_o,
  input wire logic acc_req_i,
  input wire logic [DW-1:0] acc_addr_i,
  input wire logic [1:0] acc_space_i,
  input wire logic acc_write_i,
  input wire logic acc_exec_i,
  input wire logic acc_priv_i,
  output logic acc_grant_o,
  output logic acc_trap_o,
  input wire logic fuse_normal_i,
  input wire logic pwd_valid_i,
  input wire logic [DW-1:0] pwd_i,
  input wire logic go_normal_i,
  input wire logic trace_wr_i,
  input wire logic [1:0] trace_idx_i,
  input wire logic [DW-1:0] trace_data_i,
  input wire logic func_req_i,
  output logic func_ack_o,
  output logic fuse_burn_o,
  output logic test_mode_o,
  output logic irq_o
);
  // ==========================================================
  // state
  logic [DW-1:0] fl_base_q [NPART];
  logic [DW-1:0] fl_limit_q [NPART];
  logic [ATTR_W-1:0] fl_attr_q [NPART];
  logic [DW-1:0] ram_base_q [NPART];
  logic [DW-1:0] ram_limit_q [NPART];
  logic [ATTR_W-1:0] ram_attr_q [NPART];
  logic [DW-1:0] trace_q [NTRACE];
  logic [OPM_W-1:0] opmode_q;
  logic [NEV-1:0] status_q;
  logic [NEV-1:0] status_d;
  logic [NEV-1:0] mask_q;
  logic [DW-1:0] vaddr_q;
  mpg_life_t life_q;
  mpg_life_t life_d;
  logic [DW-1:0] rdata_q;
  logic grant_q;
  logic trap_q;
  logic func_ack_q;
  logic burn_q;
  logic irq_q;
  logic test_q;

  // ==========================================================
  // register decode
  function automatic logic is_reg(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    return a == ofs;
  endfunction : is_reg

  wire logic [1:0] bank = addr_i[7:6];
  wire logic [1:0] pidx = addr_i[5:4];
  wire logic [1:0] fld = addr_i[3:2];
  wire logic wr_ok = ce_i && wr_i && priv_i;
  wire logic wr_denied = ce_i && wr_i && !priv_i;
  wire logic wr_opm = wr_ok && is_reg(addr_i, OFS_OPMODE) && !opmode_q[OPM_LOCK];
  wire logic wr_status = wr_ok && is_reg(addr_i, OFS_STATUS);
  wire logic wr_mask = wr_ok && is_reg(addr_i, OFS_MASK);
  wire logic wr_fl = wr_ok && (bank == BANK_FLASH);
  wire logic wr_ram = wr_ok && (bank == BANK_RAM);
  wire logic in_test = (life_q == LC_TEST);
  wire logic in_normal = (life_q == LC_NORMAL);
  wire logic pwd_good = pwd_valid_i && (pwd_i == TEST_PWD);

  // ==========================================================
  // access judgement
  mpg_chk_if chk_if ();

  always_comb begin
    for (int i = 0; i < NPART; i++) begin
      chk_if.fl_base[i] = fl_base_q[i];
      chk_if.fl_limit[i] = fl_limit_q[i];
      chk_if.fl_attr[i] = fl_attr_q[i];
      chk_if.ram_base[i] = ram_base_q[i];
      chk_if.ram_limit[i] = ram_limit_q[i];
      chk_if.ram_attr[i] = ram_attr_q[i];
    end
  end
  assign chk_if.opmode = opmode_q;
  assign chk_if.addr = acc_addr_i;
  assign chk_if.space = mpg_space_t'(acc_space_i);
  assign chk_if.write = acc_write_i;
  assign chk_if.exec = acc_exec_i;
  assign chk_if.priv = acc_priv_i;

  mpg_part_check mpg_part_check_inst (
    .chk(chk_if.chk)
  );

  wire logic acc_ok = ce_i && acc_req_i && chk_if.permit;
  wire logic acc_bad = ce_i && acc_req_i && !chk_if.permit;

  // ==========================================================
  // events and test-port refusals
  wire logic trace_rej = ce_i && trace_wr_i && !in_test;
  wire logic pwd_rej = pwd_valid_i && (life_q != LC_FACTORY || !pwd_good);
  wire logic cmd_rej = (go_normal_i || func_req_i) && !in_test;
  wire logic test_rej = ce_i && (pwd_rej || cmd_rej);
  wire logic [NEV-1:0] ev = {test_rej, trace_rej, wr_denied, acc_bad};

  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d = status_d & ~wdata_i[NEV-1:0];
    end
    status_d = status_d | ev;
  end

  // ==========================================================
  // life cycle
  always_comb begin
    life_d = life_q;
    case (life_q)
      LC_BOOT: begin
        life_d = fuse_normal_i ? LC_NORMAL : LC_FACTORY;
      end
      LC_FACTORY: begin
        if (pwd_good) begin
          life_d = LC_TEST;
        end
      end
      LC_TEST: begin
        if (go_normal_i) begin
          life_d = LC_NORMAL;
        end
      end
      default: begin
        life_d = LC_NORMAL;
      end
    endcase
  end

  // ==========================================================
  // read data
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = WORD_RST;
    if (bank == BANK_FLASH) begin
      if (fld == FLD_BASE) rd_mux = fl_base_q[pidx];
      else if (fld == FLD_LIMIT) rd_mux = fl_limit_q[pidx];
      else if (fld == FLD_ATTR) rd_mux = {{(DW-ATTR_W){1'b0}}, fl_attr_q[pidx]};
    end else if (bank == BANK_RAM) begin
      if (fld == FLD_BASE) rd_mux = ram_base_q[pidx];
      else if (fld == FLD_LIMIT) rd_mux = ram_limit_q[pidx];
      else if (fld == FLD_ATTR) rd_mux = {{(DW-ATTR_W){1'b0}}, ram_attr_q[pidx]};
    end else if (addr_i[7:4] == TRACE_HI) begin
      rd_mux = trace_q[fld];
    end else if (is_reg(addr_i, OFS_OPMODE)) begin
      rd_mux = {{(DW-OPM_W){1'b0}}, opmode_q};
    end else if (is_reg(addr_i, OFS_STATUS)) begin
      rd_mux = {{(DW-NEV){1'b0}}, status_q};
    end else if (is_reg(addr_i, OFS_MASK)) begin
      rd_mux = {{(DW-NEV){1'b0}}, mask_q};
    end else if (is_reg(addr_i, OFS_LIFE)) begin
      rd_mux = {{(DW-2){1'b0}}, in_normal, in_test};
    end else if (is_reg(addr_i, OFS_VADDR)) begin
      rd_mux = vaddr_q;
    end
  end

  // ==========================================================
  // flash partition registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NPART; i++) begin
        fl_base_q[i] <= BASE_RST;
        fl_limit_q[i] <= LIMIT_RST;
        fl_attr_q[i] <= ATTR_RST;
      end
    end else begin
      if (wr_fl && fld == FLD_BASE) fl_base_q[pidx] <= wdata_i;
      if (wr_fl && fld == FLD_LIMIT) fl_limit_q[pidx] <= wdata_i;
      if (wr_fl && fld == FLD_ATTR) fl_attr_q[pidx] <= wdata_i[ATTR_W-1:0];
    end
  end

  // ==========================================================
  // RAM partition registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NPART; i++) begin
        ram_base_q[i] <= BASE_RST;
        ram_limit_q[i] <= LIMIT_RST;
        ram_attr_q[i] <= ATTR_RST;
      end
    end else begin
      if (wr_ram && fld == FLD_BASE) ram_base_q[pidx] <= wdata_i;
      if (wr_ram && fld == FLD_LIMIT) ram_limit_q[pidx] <= wdata_i;
      if (wr_ram && fld == FLD_ATTR) ram_attr_q[pidx] <= wdata_i[ATTR_W-1:0];
    end
  end

  // ==========================================================
  // traceability store
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NTRACE; i++) trace_q[i] <= WORD_RST;
    end else if (ce_i && trace_wr_i && in_test) begin
      trace_q[trace_idx_i] <= trace_data_i;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      opmode_q <= OPM_RST;
      mask_q <= EV_RST;
      vaddr_q <= WORD_RST;
    end else if (ce_i) begin
      if (wr_opm) opmode_q <= wdata_i[OPM_W-1:0];
      if (wr_mask) mask_q <= wdata_i[NEV-1:0];
      if (acc_bad) vaddr_q <= acc_addr_i;
    end
  end

  // ==========================================================
  // status and life cycle state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= EV_RST;
      life_q <= LC_BOOT;
    end else if (ce_i) begin
      status_q <= status_d;
      life_q <= life_d;
    end
  end

  // ==========================================================
  // access answers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_q <= 1'b0;
      trap_q <= 1'b0;
    end else if (ce_i) begin
      grant_q <= acc_ok;
      trap_q <= acc_bad;
    end
  end

  // ==========================================================
  // bus and test-port answers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= WORD_RST;
      func_ack_q <= 1'b0;
      burn_q <= 1'b0;
      test_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      rdata_q <= rd_i ? rd_mux : WORD_RST;
      func_ack_q <= func_req_i && in_test;
      burn_q <= go_normal_i && in_test;
      test_q <= (life_d == LC_TEST);
      irq_q <= |(status_d & mask_q);
    end
  end

  assign rdata_o = rdata_q;
  assign acc_grant_o = grant_q;
  assign acc_trap_o = trap_q;
  assign func_ack_o = func_ack_q;
  assign fuse_burn_o = burn_q;
  assign test_mode_o = test_q;
  assign irq_o = irq_q;
endmodule : mpg_top

// File: tb/mpg_props.sv
// mpg_props: port-level checks of the memory partition guard
// assumes: bound to mpg_top, clock enable low only while no request is pending
`timescale 1ns/10ps
module mpg_props
  import mpg_pkg::*;
#(
  parameter logic [DW-1:0] TEST_PWD = 32'h0000_0000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic acc_req_i,
  input wire logic [1:0] acc_space_i,
  input wire logic acc_write_i,
  input wire logic acc_priv_i,
  input wire logic acc_grant_o,
  input wire logic acc_trap_o,
  input wire logic pwd_valid_i,
  input wire logic [DW-1:0] pwd_i,
  input wire logic go_normal_i,
  input wire logic func_req_i,
  input wire logic func_ack_o,
  input wire logic fuse_burn_o,
  input wire logic test_mode_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // helper state
  logic normal_seen_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) normal_seen_q <= 1'b0;
    else if (fuse_burn_o) normal_seen_q <= 1'b1;
  end

  // ==========================================================
  // assertions
  AST_ONE_ANSWER: assert property (acc_req_i && ce_i |=> acc_grant_o != acc_trap_o)
    else $error("access not answered by exactly one of grant and trap");
  AST_NO_STRAY: assert property (ce_i && !acc_req_i |=> !acc_grant_o && !acc_trap_o)
    else $error("grant or trap without a request");
  AST_SFR_USER: assert property (acc_req_i && ce_i && acc_space_i == 2'h3 && !acc_priv_i
    |=> acc_trap_o)
    else $error("user access to register space not trapped");
  AST_PRIV_GRANT: assert property (acc_req_i && ce_i && acc_priv_i && acc_space_i != 2'h0
    |=> acc_grant_o)
    else $error("privileged access refused");
  AST_ROM_WRITE: assert property (acc_req_i && ce_i && acc_space_i == 2'h0 && acc_write_i
    |=> acc_trap_o)
    else $error("write to boot memory not trapped");
  AST_FUNC_CAUSE: assert property (func_ack_o |-> $past(func_req_i) && $past(test_mode_o))
    else $error("functional test answered outside test mode");
  AST_FUNC_ACK: assert property (func_req_i && ce_i && test_mode_o |=> func_ack_o)
    else $error("functional test request in test mode not answered");
  AST_TEST_ENTRY: assert property ($rose(test_mode_o) |-> $past(pwd_valid_i)
    && $past(pwd_i) == TEST_PWD)
    else $error("test mode entered without the valid password");
  AST_NORMAL_STAYS: assert property (normal_seen_q |-> !test_mode_o)
    else $error("test mode back after switch to normal");
  AST_BURN_CAUSE: assert property (fuse_burn_o |-> $past(go_normal_i) && !test_mode_o)
    else $error("normal switch pulse without request");
  AST_RESET_QUIET: assert property (disable iff (1'b0) rst_i
    |-> !acc_grant_o && !acc_trap_o && !test_mode_o && !irq_o)
    else $error("outputs active during reset");

  // ==========================================================
  // covers
  COV_GRANT: cover property (acc_req_i ##1 acc_grant_o);
  COV_TRAP: cover property (acc_req_i ##1 acc_trap_o);
  COV_TEST: cover property ($rose(test_mode_o));
  COV_BURN: cover property (fuse_burn_o);
endmodule : mpg_props

bind mpg_top mpg_props #(.TEST_PWD(TEST_PWD)) mpg_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .acc_req_i(acc_req_i),
  .acc_space_i(acc_space_i), .acc_write_i(acc_write_i), .acc_priv_i(acc_priv_i),
  .acc_grant_o(acc_grant_o), .acc_trap_o(acc_trap_o), .pwd_valid_i(pwd_valid_i),
  .pwd_i(pwd_i), .go_normal_i(go_normal_i), .func_req_i(func_req_i),
  .func_ack_o(func_ack_o), .fuse_burn_o(fuse_burn_o), .test_mode_o(test_mode_o),
  .irq_o(irq_o)
);

// File: tb/mpg_core_model.sv
// mpg_core_model: processor core issuing checked memory accesses
// assumes: answer comes one cycle after the request edge
`timescale 1ns/10ps
module mpg_core_model
  import mpg_pkg::*;
(
  input wire logic clk_i,
  input wire logic acc_grant_i,
  input wire logic acc_trap_i,
  output logic acc_req_o,
  output logic [DW-1:0] acc_addr_o,
  output logic [1:0] acc_space_o,
  output logic acc_write_o,
  output logic acc_exec_o,
  output logic acc_priv_o
);
  initial begin
    {acc_req_o, acc_addr_o, acc_space_o, acc_write_o, acc_exec_o, acc_priv_o} = '0;
  end

  // ==========================================================
  // one access: idle cycles, one-cycle request, then the answer
  task automatic access(input logic [DW-1:0] a, input logic [1:0] sp, input logic w,
      input logic x, input logic p, input int gap, output logic g, output logic t);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    acc_req_o <= 1'b1;
    acc_addr_o <= a;
    acc_space_o <= sp;
    acc_write_o <= w;
    acc_exec_o <= x;
    acc_priv_o <= p;
    @(posedge clk_i);
    acc_req_o <= 1'b0;
    acc_addr_o <= ~a;
    #1;
    g = acc_grant_i;
    t = acc_trap_i;
  endtask : access
endmodule : mpg_core_model

// File: tb/test_memory_partition_guard.sv
// test_memory_partition_guard: register, access and test-port sequences
// assumes: single 50 MHz clock, core model on the access port
`timescale 1ns/10ps
module test_memory_partition_guard;
  import mpg_pkg::*;
  localparam logic [DW-1:0] PWD = 32'h1234_ABCD;
  logic clk_i, rst_i, ce_i, wr_i, rd_i, priv_i, fuse_normal_i, pwd_valid_i, go_normal_i;
  logic trace_wr_i, func_req_i, acc_req, acc_write, acc_exec, acc_priv;
  logic acc_grant_o, acc_trap_o, func_ack_o, fuse_burn_o, test_mode_o, irq_o;
  logic [AW-1:0] addr_i;
  logic [DW-1:0] wdata_i, rdata_o, acc_addr, pwd_i, trace_data_i;
  logic [1:0] acc_space, trace_idx_i;
  int mismatches = 0;
  int cmp_count = 0;
  int core_gap = 0;

  mpg_top #(.TEST_PWD(PWD)) mpg_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .priv_i(priv_i),
    .rdata_o(rdata_o), .acc_req_i(acc_req), .acc_addr_i(acc_addr), .acc_space_i(acc_space),
    .acc_write_i(acc_write), .acc_exec_i(acc_exec), .acc_priv_i(acc_priv),
    .acc_grant_o(acc_grant_o), .acc_trap_o(acc_trap_o), .fuse_normal_i(fuse_normal_i),
    .pwd_valid_i(pwd_valid_i), .pwd_i(pwd_i), .go_normal_i(go_normal_i),
    .trace_wr_i(trace_wr_i), .trace_idx_i(trace_idx_i), .trace_data_i(trace_data_i),
    .func_req_i(func_req_i), .func_ack_o(func_ack_o), .fuse_burn_o(fuse_burn_o),
    .test_mode_o(test_mode_o), .irq_o(irq_o));
  mpg_core_model mpg_core_model_inst (.clk_i(clk_i), .acc_grant_i(acc_grant_o),
    .acc_trap_i(acc_trap_o), .acc_req_o(acc_req), .acc_addr_o(acc_addr),
    .acc_space_o(acc_space), .acc_write_o(acc_write), .acc_exec_o(acc_exec),
    .acc_priv_o(acc_priv));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ==========================================================
  // tasks
  task chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic p);
    @(posedge clk_i);
    {addr_i, wdata_i, priv_i, wr_i} <= {a, d, p, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask : rd

  task acc(input logic [DW-1:0] a, input logic [1:0] sp, input logic w, input logic x,
      input logic p, input logic et);
    logic g;
    logic t;
    mpg_core_model_inst.access(a, sp, w, x, p, core_gap, g, t);
    chk(32'({t, g}), 32'({et, ~et}));
  endtask : acc

  task tp(input logic [3:0] k, input logic [DW-1:0] v);
    @(posedge clk_i);
    {pwd_valid_i, go_normal_i, trace_wr_i, func_req_i} <= k;
    {pwd_i, trace_data_i} <= {v, v};
    @(posedge clk_i);
    {pwd_valid_i, go_normal_i, trace_wr_i, func_req_i} <= 4'h0;
    #1;
  endtask : tp

  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // tests
  initial begin
    {rst_i, wr_i, rd_i, priv_i, fuse_normal_i, addr_i, wdata_i} = '0;
    {pwd_valid_i, go_normal_i, trace_wr_i, func_req_i, pwd_i, trace_data_i} = '0;
    ce_i = 1'b1;
    trace_idx_i = 2'h2;
    #1 rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_OPMODE, 32'h0);
    rd(8'h40, BASE_RST);
    rd(8'h94, LIMIT_RST);
    rd(8'h48, 32'h0);
    rd(OFS_LIFE, 32'h0);
    rd(8'h3C, 32'h0);
    acc(32'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(32'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    $display("test defaults done");
    wr(8'h40, 32'h0000_1000, 1'b0);
    rd(8'h40, BASE_RST);
    rd(OFS_STATUS, 32'h3);
    wr(8'h40, 32'h0000_1000, 1'b1);
    wr(8'h44, 32'h0000_1FFF, 1'b1);
    wr(8'h48, 32'h3, 1'b1);
    wr(8'h90, 32'h0000_0100, 1'b1);
    wr(8'h94, 32'h0000_01FF, 1'b1);
    wr(8'h98, 32'h7, 1'b1);
    rd(8'h44, 32'h0000_1FFF);
    rd(8'h98, 32'h7);
    acc(32'h1000, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(32'h1FFF, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(32'h2000, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(32'h0FFF, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(32'h1000, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1);
    acc(32'h1000, 2'h1, 1'b1, 1'b0, 1'b0, 1'b1);
    acc(32'h0180, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0);
    acc(32'h1000, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
    core_gap = 3;
    acc(32'h0010, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(32'h0010, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0);
    core_gap = 0;
    acc(32'h55AA, 2'h0, 1'b1, 1'b0, 1'b1, 1'b1);
    rd(OFS_VADDR, 32'h55AA);
    $display("test partitions done");
    wr(OFS_OPMODE, 32'h2, 1'b0);
    acc(32'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(OFS_OPMODE, 32'h2, 1'b1);
    acc(32'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(OFS_OPMODE, 32'h9, 1'b1);
    acc(32'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(OFS_OPMODE, 32'h0, 1'b1);
    rd(OFS_OPMODE, 32'h9);
    chk(32'(irq_o), 32'h0);
    wr(OFS_MASK, 32'h1, 1'b1);
    repeat (2) @(posedge clk_i);
    #1;
    chk(32'(irq_o), 32'h1);
    wr(OFS_STATUS, 32'hF, 1'b1);
    rd(OFS_STATUS, 32'h0);
    chk(32'(irq_o), 32'h0);
    $display("test mode selector and interrupt done");
    tp(4'h1, 32'h0);
    chk(32'(func_ack_o), 32'h0);
    tp(4'h8, ~PWD);
    chk(32'(test_mode_o), 32'h0);
    tp(4'h8, PWD);
    chk(32'(test_mode_o), 32'h1);
    tp(4'h1, 32'h0);
    chk(32'(func_ack_o), 32'h1);
    tp(4'h2, 32'hCAFE_0001);
    rd(8'h28, 32'hCAFE_0001);
    tp(4'h4, 32'h0);
    chk(32'({fuse_burn_o, test_mode_o}), 32'h2);
    tp(4'h2, 32'h1111_2222);
    rd(8'h28, 32'hCAFE_0001);
    tp(4'h1, 32'h0);
    chk(32'(func_ack_o), 32'h0);
    tp(4'h8, PWD);
    chk(32'(test_mode_o), 32'h0);
    rd(OFS_LIFE, 32'h2);
    rd(OFS_STATUS, 32'hC);
    chk(32'(irq_o), 32'h0);
    @(posedge clk_i);
    {rst_i, fuse_normal_i} <= 2'h3;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_LIFE, 32'h2);
    rd(8'h40, BASE_RST);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(OFS_MASK, 32'hF, 1'b1);
    ce_i <= 1'b1;
    rd(OFS_MASK, 32'h0);
    wr(8'h40, 32'h0, 1'b1);
    wr(8'h44, 32'h0000_FFFF, 1'b1);
    wr(8'h48, 32'h5, 1'b1);
    acc(32'h0010, 2'h1, 1'b1, 1'b0, 1'b0, 1'b1);
    wr(OFS_OPMODE, 32'h4, 1'b1);
    acc(32'h0010, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    tp(4'h8, PWD);
    chk(32'(test_mode_o), 32'h0);
    $display("test life cycle done");
    final_report();
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    final_report();
  end
endmodule : test_memory_partition_guard
